// >>> verilog/rspp_pkg.sv
package rspp_pkg;

   localparam int unsigned CLK_HZ        = 32'h0262_5A00;
   localparam int unsigned BAUD_MAX      = 32'h0001_C200;
   localparam int unsigned DIV_MIN       = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
   localparam int unsigned DIV_W         = 16;
   localparam int unsigned SECTION_BYTES = 32'h0000_0400;
   localparam int unsigned SECTIONS      = 2;
   localparam int unsigned BOOT_US       = 10;
   localparam int unsigned BOOT_CYCLES   = (BOOT_US * (CLK_HZ / 1000)) / 1000;
   localparam int unsigned ACK_WAIT_MS   = 20;
   localparam int unsigned ACK_CYCLES    = ACK_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned CHAR_BITS     = 10;

   localparam logic [7:0] CHAR_STX = 8'h02;
   localparam logic [7:0] CHAR_ETX = 8'h03;
   localparam logic [7:0] CHAR_DLE = 8'h10;
   localparam logic [7:0] CHAR_NAK = 8'h15;
   localparam logic [15:0] DIV_RESET = 16'h015C;

   typedef enum logic [2:0] {
      PROTO_ASCII,
      PROTO_STXETX,
      PROTO_3964R,
      PROTO_USS,
      PROTO_MODBUS
   } rspp_proto_t;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_HEAD,
      PH_DATA,
      PH_TAIL,
      PH_BCC,
      PH_ACK
   } rspp_phase_t;

   typedef struct packed {
      logic        ptp_sel;
      rspp_proto_t proto;
      logic [15:0] baud_div;
   } rspp_cfg_t;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } rspp_send_t;

   typedef struct packed {
      logic ptp_active;
      logic ready;
      logic tx_busy;
      logic ack_wait;
      logic ack_ok;
      logic ack_nak;
      logic ack_timeout;
      logic rx_overflow;
   } rspp_status_t;

endpackage

// >>> verilog/rspp_port.sv
`timescale 1ns/100ps
// What this block does
// RULE1: After reset serve multipoint role; go point-to-point only after configuration.
// RULE2: Configurer selects point-to-point and loads config; ready after boot delay.
// RULE3: Five framings selectable: ASCII, STX/ETX, 3964R, USS, Modbus.
// RULE4: Sent bytes queue in a 2x1024 byte FIFO before leaving on line.
// RULE5: Received bytes go into a 2x1024 byte FIFO read by the CPU.
// RULE6: Framing is added on send for STX/ETX, 3964R and USS; control characters are stripped on receive for STX/ETX and 3964R only.
// RULE7: Track partner acknowledgement for 3964R, USS, Modbus; none for ASCII, STX/ETX.
// RULE8: Status returned on send requests includes partner acknowledgement state.
// RULE9: For USS and Modbus the program reads the reply after each send.
// RULE10: Half duplex on one pair; never transmit and receive together.
// RULE11: Bit rates up to 115.2 kilobaud.
// RULE12: Parameters applied at runtime by configure request, from parameter block.
// RULE13: Request-to-send drives the line only while transmitting, until last stop bit.
// RULE14: Receive FIFO full discards bytes and raises an overflow flag.
module rspp_port #(
   parameter int unsigned DEPTH      = rspp_pkg::SECTIONS * rspp_pkg::SECTION_BYTES,
   parameter int unsigned ACK_CYCLES = rspp_pkg::ACK_CYCLES
) (
   input  wire logic                  clock_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  clk_en_in,
   input  wire logic                  port_configure_request_in,
   input  wire rspp_pkg::rspp_cfg_t   cfg_in,
   input  wire logic                  port_send_request_in,
   input  wire rspp_pkg::rspp_send_t  send_in,
   output logic                       send_ready_out,
   input  wire logic                  port_receive_request_in,
   output logic                       rx_avail_out,
   output logic                       rx_valid_out,
   output logic [7:0]                 rx_data_out,
   output rspp_pkg::rspp_status_t     request_return_status_out,
   input  wire logic                  line_rx_in,
   output logic                       line_tx_out,
   output logic                       line_tx_oe_out
);

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic                  point_to_point_mode;
      logic [15:0]           boot_cnt;
      rspp_pkg::rspp_proto_t proto;
      logic [15:0]           div;
      rspp_pkg::rspp_phase_t phase;
      logic [7:0]            bcc;
      logic                  tail2;
      logic                  tx_on;
      logic [9:0]            tx_sh;
      logic [3:0]            tx_bits;
      logic [15:0]           tx_baud;
      logic                  rx_on;
      logic [8:0]            rx_sh;
      logic [3:0]            rx_bits;
      logic [15:0]           rx_baud;
      logic [AW:0]           tx_wr;
      logic [AW:0]           tx_rd;
      logic [AW:0]           rx_wr;
      logic [AW:0]           rx_rd;
      logic [31:0]           ack_cnt;
      logic                  ack_ok;
      logic                  ack_nak;
      logic                  ack_to;
      logic                  ovf;
      logic                  rx_valid;
   } rspp_st_t;

   rspp_st_t   st_reg;
   rspp_st_t   st_next;
   logic [8:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic [7:0] rx_data_reg;
   logic       tx_push;
   logic       rx_push;
   logic       rx_pop;
   logic [7:0] rx_byte;

   function automatic logic rspp_acked(input rspp_pkg::rspp_proto_t p);
      return (p == rspp_pkg::PROTO_3964R) || (p == rspp_pkg::PROTO_USS) ||
             (p == rspp_pkg::PROTO_MODBUS);
   endfunction

   function automatic logic rspp_full(input logic [AW:0] wr, input logic [AW:0] rd);
      return (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
   endfunction

   // Control characters that belong to the framing, not to the payload
   function automatic logic rspp_strip(input rspp_pkg::rspp_proto_t p, input logic [7:0] b);
      case (p)
         rspp_pkg::PROTO_STXETX: return (b == rspp_pkg::CHAR_STX) || (b == rspp_pkg::CHAR_ETX);
         rspp_pkg::PROTO_3964R:  return (b == rspp_pkg::CHAR_STX) || (b == rspp_pkg::CHAR_ETX) ||
                                        (b == rspp_pkg::CHAR_DLE) || (b == rspp_pkg::CHAR_NAK);
         default:                return 1'b0;
      endcase
   endfunction

   function automatic logic [9:0] rspp_char(input logic [7:0] b);
      return {1'b1, b, 1'b0};
   endfunction

   logic       live;
   logic       tx_empty;
   logic [8:0] tx_head_word;

   always_comb begin
      live          = st_reg.point_to_point_mode && (st_reg.boot_cnt == 16'h0000);
      tx_empty      = (st_reg.tx_wr == st_reg.tx_rd);
      tx_head_word  = tx_mem[st_reg.tx_rd[AW-1:0]];
      tx_push       = port_send_request_in && live && !rspp_full(st_reg.tx_wr, st_reg.tx_rd);
      rx_pop        = port_receive_request_in && (st_reg.rx_wr != st_reg.rx_rd);
      rx_push       = 1'b0;
      rx_byte       = st_reg.rx_sh[7:0];
      st_next       = st_reg;
      st_next.rx_valid = rx_pop;

      if (port_configure_request_in) begin // RULE12
         st_next.point_to_point_mode      = cfg_in.ptp_sel; // RULE1
         st_next.proto    = cfg_in.proto; // RULE3
         st_next.div      = (cfg_in.baud_div < 16'(rspp_pkg::DIV_MIN)) ?
                            16'(rspp_pkg::DIV_MIN) : cfg_in.baud_div; // RULE11
         st_next.boot_cnt = 16'(rspp_pkg::BOOT_CYCLES); // RULE2
         st_next.phase    = rspp_pkg::PH_IDLE;
         st_next.ovf      = 1'b0;
      end else if (st_reg.boot_cnt != 16'h0000) begin
         st_next.boot_cnt = st_reg.boot_cnt - 16'h0001;
      end

      if (tx_push) begin // RULE4
         st_next.tx_wr = st_reg.tx_wr + (AW + 1)'(1);
      end
      if (rx_pop) begin // RULE5
         st_next.rx_rd = st_reg.rx_rd + (AW + 1)'(1);
      end

      // Character shifter
      if (st_reg.tx_on) begin
         if (st_reg.tx_baud == st_reg.div - 16'h0001) begin
            st_next.tx_baud = 16'h0000;
            st_next.tx_sh   = {1'b1, st_reg.tx_sh[9:1]};
            st_next.tx_bits = st_reg.tx_bits - 4'h1;
            st_next.tx_on   = (st_reg.tx_bits != 4'h1); // RULE13
         end else begin
            st_next.tx_baud = st_reg.tx_baud + 16'h0001;
         end
      end else if (live && !st_reg.rx_on && !port_configure_request_in) begin // RULE10
         // Frame sequencer feeds the shifter one character at a time
         case (st_reg.phase)
            rspp_pkg::PH_IDLE: begin
               if (!tx_empty) begin
                  st_next.ack_ok  = 1'b0;
                  st_next.ack_nak = 1'b0;
                  st_next.ack_to  = 1'b0;
                  st_next.bcc     = 8'h00;
                  st_next.phase   = (st_reg.proto == rspp_pkg::PROTO_ASCII ||
                                     st_reg.proto == rspp_pkg::PROTO_MODBUS) ?
                                    rspp_pkg::PH_DATA : rspp_pkg::PH_HEAD; // RULE6
               end
            end
            rspp_pkg::PH_HEAD: begin
               st_next.tx_sh = rspp_char(rspp_pkg::CHAR_STX); // RULE6
               st_next.tx_on = 1'b1;
               st_next.bcc   = (st_reg.proto == rspp_pkg::PROTO_USS) ? rspp_pkg::CHAR_STX : 8'h00;
               st_next.phase = rspp_pkg::PH_DATA;
            end
            rspp_pkg::PH_DATA: begin
               if (!tx_empty) begin
                  st_next.tx_sh = rspp_char(tx_head_word[7:0]);
                  st_next.tx_on = 1'b1;
                  st_next.bcc   = st_reg.bcc ^ tx_head_word[7:0];
                  st_next.tx_rd = st_reg.tx_rd + (AW + 1)'(1);
                  if (tx_head_word[8]) begin
                     case (st_reg.proto)
                        rspp_pkg::PROTO_STXETX: st_next.phase = rspp_pkg::PH_TAIL;
                        rspp_pkg::PROTO_3964R:  st_next.phase = rspp_pkg::PH_TAIL;
                        rspp_pkg::PROTO_USS:    st_next.phase = rspp_pkg::PH_BCC;
                        rspp_pkg::PROTO_MODBUS: st_next.phase = rspp_pkg::PH_ACK;
                        default:                st_next.phase = rspp_pkg::PH_IDLE;
                     endcase
                     st_next.tail2   = (st_reg.proto == rspp_pkg::PROTO_3964R);
                     st_next.ack_cnt = 32'h0000_0000;
                  end
               end
            end
            rspp_pkg::PH_TAIL: begin
               st_next.tx_sh = rspp_char(st_reg.tail2 ? rspp_pkg::CHAR_DLE : rspp_pkg::CHAR_ETX);
               st_next.tx_on = 1'b1;
               st_next.bcc   = st_reg.bcc ^ st_next.tx_sh[8:1];
               st_next.tail2 = 1'b0;
               if (!st_reg.tail2) begin
                  st_next.phase = rspp_acked(st_reg.proto) ? rspp_pkg::PH_BCC : rspp_pkg::PH_IDLE;
               end
            end
            rspp_pkg::PH_BCC: begin
               st_next.tx_sh   = rspp_char(st_reg.bcc);
               st_next.tx_on   = 1'b1;
               st_next.ack_cnt = 32'h0000_0000;
               st_next.phase   = rspp_pkg::PH_ACK; // RULE7
            end
            rspp_pkg::PH_ACK: begin
               if (st_reg.ack_cnt == ACK_CYCLES - 1) begin // RULE7
                  st_next.ack_to = 1'b1;
                  st_next.phase  = rspp_pkg::PH_IDLE;
               end else begin
                  st_next.ack_cnt = st_reg.ack_cnt + 32'h0000_0001;
               end
            end
            default: st_next.phase = rspp_pkg::PH_IDLE;
         endcase
         st_next.tx_bits = st_next.tx_on ? 4'(rspp_pkg::CHAR_BITS) : st_reg.tx_bits;
      end

      // Receiver, held off while the driver is on
      if (st_reg.rx_on) begin
         if (st_reg.rx_baud == 16'h0000) begin
            st_next.rx_baud = st_reg.div - 16'h0001;
            st_next.rx_sh   = {line_rx_in, st_reg.rx_sh[8:1]};
            st_next.rx_bits = st_reg.rx_bits - 4'h1;
            if (st_reg.rx_bits == 4'h1) begin
               st_next.rx_on = 1'b0;
               rx_byte       = st_reg.rx_sh[8:1];
               if (line_rx_in && st_reg.phase == rspp_pkg::PH_ACK) begin // RULE7
                  st_next.phase   = rspp_pkg::PH_IDLE;
                  st_next.ack_nak = (rx_byte == rspp_pkg::CHAR_NAK);
                  st_next.ack_ok  = (rx_byte != rspp_pkg::CHAR_NAK);
               end
               if (line_rx_in && !rspp_strip(st_reg.proto, rx_byte)) begin // RULE6
                  if (rspp_full(st_reg.rx_wr, st_reg.rx_rd)) begin
                     st_next.ovf = 1'b1; // RULE14
                  end else begin
                     rx_push       = 1'b1; // RULE5
                     st_next.rx_wr = st_reg.rx_wr + (AW + 1)'(1);
                  end
               end
            end
         end else begin
            st_next.rx_baud = st_reg.rx_baud - 16'h0001;
         end
      end else if (live && !st_reg.tx_on && !st_next.tx_on && !line_rx_in) begin // RULE10
         st_next.rx_on   = 1'b1;
         st_next.rx_bits = 4'(rspp_pkg::CHAR_BITS - 1);
         st_next.rx_baud = st_reg.div + (st_reg.div >> 1) - 16'h0001;
      end

      if (sys_rst_in) begin
         st_next          = '0;
         st_next.div      = rspp_pkg::DIV_RESET;
         st_next.tx_sh    = 10'h3FF;
         st_next.proto    = rspp_pkg::PROTO_ASCII;
         st_next.phase    = rspp_pkg::PH_IDLE;
         st_next.point_to_point_mode      = 1'b0; // RULE1
      end
   end

   always_ff @(posedge clock_in) begin
      if (clk_en_in || sys_rst_in) begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge clock_in) begin
      if (clk_en_in && !sys_rst_in) begin
         if (tx_push) begin
            tx_mem[st_reg.tx_wr[AW-1:0]] <= send_in;
         end
         if (rx_push) begin
            rx_mem[st_reg.rx_wr[AW-1:0]] <= rx_byte;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rx_data_reg <= 8'h00;
      end else if (clk_en_in && rx_pop) begin
         rx_data_reg <= rx_mem[st_reg.rx_rd[AW-1:0]];
      end
   end

   always_comb begin
      send_ready_out  = live && !rspp_full(st_reg.tx_wr, st_reg.tx_rd);
      rx_avail_out    = (st_reg.rx_wr != st_reg.rx_rd);
      rx_valid_out    = st_reg.rx_valid;
      rx_data_out     = rx_data_reg;
      line_tx_out     = st_reg.tx_sh[0];
      line_tx_oe_out  = st_reg.tx_on; // RULE13
      request_return_status_out.ptp_active  = st_reg.point_to_point_mode;
      request_return_status_out.ready       = live;
      request_return_status_out.tx_busy     = st_reg.tx_on || (st_reg.phase != rspp_pkg::PH_IDLE);
      request_return_status_out.ack_wait    = (st_reg.phase == rspp_pkg::PH_ACK); // RULE8
      request_return_status_out.ack_ok      = st_reg.ack_ok;
      request_return_status_out.ack_nak     = st_reg.ack_nak;
      request_return_status_out.ack_timeout = st_reg.ack_to;
      request_return_status_out.rx_overflow = st_reg.ovf;
   end

endmodule

// >>> sim/rspp_port_checker.sv
`timescale 1ns/100ps
module rspp_port_checker (
   input wire logic                   clock_in,
   input wire logic                   sys_rst_in,
   input wire logic                   clk_en_in,
   input wire logic                   port_configure_request_in,
   input wire rspp_pkg::rspp_cfg_t    cfg_in,
   input wire logic                   port_receive_request_in,
   input wire logic                   send_ready_out,
   input wire logic                   rx_avail_out,
   input wire logic                   rx_valid_out,
   input wire rspp_pkg::rspp_status_t request_return_status_out,
   input wire logic                   line_tx_out,
   input wire logic                   line_tx_oe_out
);
   rspp_pkg::rspp_status_t st;
   rspp_pkg::rspp_proto_t  proto_reg;
   rspp_pkg::rspp_proto_t  proto_next;
   logic                   cfg_go;
   assign st = request_return_status_out;
   assign cfg_go = port_configure_request_in && clk_en_in;
   // Last configured framing, for the ack check
   always_comb begin
      proto_next = cfg_go ? cfg_in.proto : proto_reg;
   end
   always_ff @(posedge clock_in) begin
      proto_reg <= sys_rst_in ? rspp_pkg::PROTO_ASCII : proto_next;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   property p_reset;
      disable iff (1'b0)
      sys_rst_in |=> !st.ptp_active && !send_ready_out && line_tx_out && !line_tx_oe_out;
   endproperty
   a_reset: assert property (p_reset) else $error("state after reset");
   property p_mp; cfg_go && !cfg_in.ptp_sel |=> !st.ptp_active && !st.ready; endproperty
   a_mp: assert property (p_mp) else $error("left multipoint role");
   property p_boot; cfg_go && cfg_in.ptp_sel |=> (st.ptp_active && !st.ready) [*8]; endproperty
   a_boot: assert property (p_boot) else $error("no boot delay");
   property p_sready; send_ready_out |-> st.ready && st.ptp_active; endproperty
   a_sready: assert property (p_sready) else $error("send accepted too early");
   property p_idle; !line_tx_oe_out |-> line_tx_out; endproperty
   a_idle: assert property (p_idle) else $error("line not idle");
   property p_start; $rose(line_tx_oe_out) |-> !line_tx_out; endproperty
   a_start: assert property (p_start) else $error("driver on without start");
   property p_stop; $fell(line_tx_oe_out) |-> $past(line_tx_out); endproperty
   a_stop: assert property (p_stop) else $error("driver off before stop");
   property p_ack;
      $rose(st.ack_wait) |->
         proto_reg inside {rspp_pkg::PROTO_3964R, rspp_pkg::PROTO_USS, rspp_pkg::PROTO_MODBUS};
   endproperty
   a_ack: assert property (p_ack) else $error("ack wait in plain framing");
   property p_pop;
      port_receive_request_in && rx_avail_out && clk_en_in |=> rx_valid_out;
   endproperty
   a_pop: assert property (p_pop) else $error("pop not answered");
   property p_ovf; st.rx_overflow && !cfg_go |=> st.rx_overflow; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag lost");
   property p_half; line_tx_oe_out && !rx_avail_out |=> !rx_avail_out; endproperty
   a_half: assert property (p_half) else $error("received while sending");
endmodule
bind rspp_port rspp_port_checker i_checker (.*);

// >>> sim/rspp_peer.sv
`timescale 1ns/100ps
module rspp_peer #(
   parameter int BIT = 348
) (
   input  wire logic clock_in,
   input  wire logic line_tx_in,
   input  wire logic line_oe_in,
   output logic      line_rx_out
);
   logic       drive_reg = 1'b0;
   logic       bit_reg   = 1'b1;
   logic [7:0] shift;
   logic [7:0] got [$];
   // Failsafe bias holds mark; own driver echoes back
   assign line_rx_out = drive_reg ? bit_reg : (line_oe_in ? line_tx_in : 1'b1);
   initial begin
      forever begin
         @(negedge clock_in);
         if (line_oe_in && !line_tx_in) begin
            repeat (BIT + BIT / 2) @(negedge clock_in);
            for (int i = 0; i < 8; i++) begin
               shift[i] = line_tx_in;
               repeat (BIT) @(negedge clock_in);
            end
            got.push_back(shift);
         end
      end
   end
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock_in);
         drive_reg <= 1'b1;
         bit_reg <= fr[i];
         repeat (BIT - 1) @(posedge clock_in);
      end
      @(posedge clock_in);
      drive_reg <= 1'b0;
   endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      rspp_pkg::rspp_proto_t proto;
      logic [2:0]            n;
      logic [39:0]           exp;
      logic                  acked;
      logic [8:0]            reply;
      logic [2:0]            ack;
   } rspp_row_t;
   logic                   clock_in = 1'b0;
   logic                   sys_rst_in = 1'b1;
   logic                   clk_en_in = 1'b1;
   logic                   port_configure_request_in = 1'b0;
   rspp_pkg::rspp_cfg_t    cfg_in = '0;
   logic                   port_send_request_in = 1'b0;
   rspp_pkg::rspp_send_t   send_in = '0;
   logic                   port_receive_request_in = 1'b0;
   logic                   send_ready_out;
   logic                   rx_avail_out;
   logic                   rx_valid_out;
   logic [7:0]             rx_data_out;
   rspp_pkg::rspp_status_t request_return_status_out;
   logic                   line_rx_in;
   logic                   line_tx_out;
   logic                   line_tx_oe_out;
   rspp_row_t              rows [5];
   int                     err_count = 0;
   int                     tests_run = 0;
   rspp_port #(.DEPTH(2), .ACK_CYCLES(8000)) i_dut (.*);
   rspp_peer i_peer (
      .clock_in    (clock_in),
      .line_tx_in  (line_tx_out),
      .line_oe_in  (line_tx_oe_out),
      .line_rx_out (line_rx_in)
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic cfg(input rspp_pkg::rspp_proto_t p, input logic point_to_point_mode);
      port_configure_request_in <= 1'b1;
      cfg_in <= '{ptp_sel: point_to_point_mode, proto: p, baud_div: rspp_pkg::DIV_RESET};
      tick(1);
      port_configure_request_in <= 1'b0;
      tick(390);
      check(request_return_status_out.ready, 1'b0);
      tick(20);
      check(request_return_status_out.ready, point_to_point_mode);
      check(send_ready_out, point_to_point_mode);
   endtask
   task automatic push(input logic [7:0] b, input logic last);
      int k;
      k = 0;
      port_send_request_in <= 1'b1;
      send_in <= '{last: last, data: b};
      tick(1);
      while (!send_ready_out && k < 20000) begin
         tick(1);
         k++;
      end
      check(k < 20000, 1'b1);
   endtask
   task automatic wait_tx(input int n);
      int k;
      k = 0;
      while ((i_peer.got.size() < n || line_tx_oe_out) && k < 60000) begin
         tick(1);
         k++;
      end
      check(k < 60000, 1'b1);
   endtask
   task automatic pop(input logic [7:0] exp);
      port_receive_request_in <= 1'b1;
      tick(1);
      port_receive_request_in <= 1'b0;
      tick(1);
      check(rx_valid_out, 1'b1);
      check(rx_data_out, exp);
   endtask
   initial begin
      forever #12.5 clock_in = ~clock_in;
   end
   initial begin
      #2400000;
      err_count++;
      final_report();
   end
   initial begin
      rows[0] = '{rspp_pkg::PROTO_ASCII, 3'h1, {8'h41, 32'h0}, 1'b0, 9'h000, 3'h0};
      rows[1] = '{rspp_pkg::PROTO_STXETX, 3'h3, {24'h02_4103, 16'h0}, 1'b0, 9'h000, 3'h0};
      rows[2] = '{rspp_pkg::PROTO_3964R, 3'h5, {32'h0241_1003, 8'h41 ^ 8'h10 ^ 8'h03},
                  1'b1, 9'h115, 3'h2};
      rows[3] = '{rspp_pkg::PROTO_USS, 3'h3, {16'h0241, 8'h02 ^ 8'h41, 16'h0},
                  1'b1, 9'h15A, 3'h4};
      rows[4] = '{rspp_pkg::PROTO_MODBUS, 3'h1, {8'h41, 32'h0}, 1'b1, 9'h000, 3'h1};
      tick(8);
      sys_rst_in <= 1'b0;
      tick(1);
      check(request_return_status_out, 8'h00);
      check({line_tx_out, line_tx_oe_out, send_ready_out}, 3'h4);
      cfg(rspp_pkg::PROTO_ASCII, 1'b0);
      // All five framings in turn
      for (int r = 0; r < 5; r++) begin
         i_peer.got.delete();
         cfg(rows[r].proto, 1'b1);
         push(8'h41, 1'b1);
         port_send_request_in <= 1'b0;
         wait_tx(rows[r].n);
         for (int k = 0; k < rows[r].n; k++) begin
            check(i_peer.got[k], rows[r].exp[39 - 8 * k -: 8]);
         end
         check(request_return_status_out.ack_wait, rows[r].acked);
         if (rows[r].reply[8]) begin
            i_peer.send_byte(rows[r].reply[7:0]);
         end
         for (int k = 0; k < 20000 && request_return_status_out.ack_wait; k++) begin
            tick(1);
         end
         check({request_return_status_out.ack_ok, request_return_status_out.ack_nak,
                request_return_status_out.ack_timeout}, rows[r].ack);
         check(rx_avail_out, rows[r].proto == rspp_pkg::PROTO_USS);
         if (rx_avail_out) begin
            pop(8'h5A);
         end
      end
      cfg(rspp_pkg::PROTO_ASCII, 1'b1);
      i_peer.send_byte(8'h61);
      i_peer.send_byte(8'h62);
      i_peer.send_byte(8'h63);
      tick(4);
      check(request_return_status_out.rx_overflow, 1'b1);
      pop(8'h61);
      pop(8'h62);
      check(rx_avail_out, 1'b0);
      i_peer.got.delete();
      cfg(rspp_pkg::PROTO_ASCII, 1'b1);
      check(request_return_status_out.rx_overflow, 1'b0);
      push(8'h31, 1'b0);
      push(8'h32, 1'b0);
      push(8'h33, 1'b1);
      check(request_return_status_out.tx_busy, 1'b1);
      port_send_request_in <= 1'b0;
      wait_tx(3);
      for (int k = 0; k < 3; k++) begin
         check(i_peer.got[k], 8'h31 + k);
      end
      // Configure while frozen is not taken
      clk_en_in <= 1'b0;
      port_configure_request_in <= 1'b1;
      tick(4);
      port_configure_request_in <= 1'b0;
      clk_en_in <= 1'b1;
      tick(2);
      check(request_return_status_out.ready, 1'b1);
      final_report();
   end
endmodule
